/* File: logic/ssw_pkg.sv */
/*
  shared names for the pilot sleep and wake link: message codes, timing figures
  and the cycle counts derived from them. assumes a single 125 MHz clock.
*/
`default_nettype none

package ssw_pkg;

  localparam int unsigned VAL_W   = 16;
  localparam int unsigned DUTY_W  = 7;
  localparam int unsigned OFS_W   = 32;
  localparam int unsigned WAIT_W  = 48;

  // clock and time figures in their own units
  localparam logic [63:0] CLK_HZ           = 64'h0000_0000_0773_5940;
  localparam logic [63:0] PWM_HZ           = 64'h0000_0000_0000_03E8;
  localparam logic [63:0] DUTY_PCT         = 64'h0000_0000_0000_0005;
  localparam logic [63:0] PCT_FULL         = 64'h0000_0000_0000_0064;
  localparam logic [63:0] MS_PER_S         = 64'h0000_0000_0000_03E8;
  localparam logic [63:0] TWAIT_BASE_MS    = 64'h0000_0000_0000_07D0;
  localparam logic [63:0] TWAIT_FACTOR_X10 = 64'h0000_0000_0000_000B;
  localparam logic [63:0] TEN              = 64'h0000_0000_0000_000A;
  localparam logic [63:0] TWAIT_SLEW_APS   = 64'h0000_0000_0000_0014;
  localparam logic [63:0] STEP_MS          = 64'h0000_0000_0000_0064;
  localparam logic [63:0] TOGGLE_HOLD_MS   = 64'h0000_0000_0000_000A;

  // derived cycle counts
  localparam int unsigned PWM_PERIOD_CYCLES = 32'(CLK_HZ / PWM_HZ);
  localparam int unsigned PWM_HIGH_CYCLES   = 32'(CLK_HZ / PWM_HZ * DUTY_PCT / PCT_FULL);
  localparam int unsigned TWAIT_BASE_CYCLES = 32'(CLK_HZ * TWAIT_BASE_MS / MS_PER_S);
  localparam int unsigned CYCLES_PER_AMP    = 32'(CLK_HZ * TWAIT_FACTOR_X10 / (TEN * TWAIT_SLEW_APS));
  localparam int unsigned STEP_CYCLES       = 32'(CLK_HZ * STEP_MS / MS_PER_S);
  localparam int unsigned TOGGLE_CYCLES     = 32'(CLK_HZ * TOGGLE_HOLD_MS / MS_PER_S);
  localparam logic [DUTY_W-1:0] DUTY_CODE   = DUTY_W'(DUTY_PCT);
  localparam logic [DUTY_W-1:0] DUTY_OFF    = 7'h00;

  typedef enum logic [2:0] {
    SSW_REQ_NONE,
    SSW_REQ_PARAM,
    SSW_REQ_CURRENT,
    SSW_REQ_POWER,
    SSW_REQ_STOP
  } ssw_req_t;

  typedef enum logic [2:0] {
    SSW_RSP_NONE,
    SSW_RSP_PARAM,
    SSW_RSP_CURRENT,
    SSW_RSP_POWER,
    SSW_RSP_STOP,
    SSW_RSP_FAILED
  } ssw_rsp_t;

endpackage

`default_nettype wire

/* File: logic/ssw_pilot_if.sv */
/*
  one gun's link between charger and vehicle: message strobes, data link pause
  and the pilot line levels. the testbench ties both modports to one instance.
*/
`timescale 1ns/1ns
`default_nettype none

interface ssw_pilot_if;
  logic                        req_valid;
  ssw_pkg::ssw_req_t           req_code;
  logic                        req_arg;
  logic [ssw_pkg::VAL_W-1:0]   req_current;
  logic [ssw_pkg::VAL_W-1:0]   req_voltage;
  logic                        dlink_pause;
  logic                        pilot_c;
  logic                        rsp_valid;
  ssw_pkg::ssw_rsp_t           rsp_code;
  logic [ssw_pkg::VAL_W-1:0]   rsp_vmin;
  logic [ssw_pkg::VAL_W-1:0]   rsp_vmax;
  logic [ssw_pkg::VAL_W-1:0]   rsp_imin;
  logic [ssw_pkg::VAL_W-1:0]   rsp_imax;
  logic [ssw_pkg::VAL_W-1:0]   rsp_pmax;
  logic                        pwm_on;
  logic [ssw_pkg::DUTY_W-1:0]  pwm_duty;
  logic                        pilot_wave;

  modport charger (
    input  req_valid, req_code, req_arg, req_current, req_voltage, dlink_pause, pilot_c,
    output rsp_valid, rsp_code, rsp_vmin, rsp_vmax, rsp_imin, rsp_imax, rsp_pmax,
    output pwm_on, pwm_duty, pilot_wave
  );

  modport vehicle (
    output req_valid, req_code, req_arg, req_current, req_voltage, dlink_pause, pilot_c,
    input  rsp_valid, rsp_code, rsp_vmin, rsp_vmax, rsp_imin, rsp_imax, rsp_pmax,
    input  pwm_on, pwm_duty, pilot_wave
  );
endinterface

`default_nettype wire

/* File: logic/ssw_vehicle_end.sv */
/*
  vehicle end of one gun: runs discovery, charging steps, stop, pause, data link
  pause and the single wake toggle. assumes one clock shared with the charger.
*/
`timescale 1ns/1ns
`default_nettype none

module ssw_vehicle_end #(
  parameter int unsigned WAIT_BASE     = ssw_pkg::TWAIT_BASE_CYCLES,
  parameter int unsigned CYC_PER_AMP   = ssw_pkg::CYCLES_PER_AMP,
  parameter int unsigned STEP_CYCLES   = ssw_pkg::STEP_CYCLES,
  parameter int unsigned TOGGLE_CYCLES = ssw_pkg::TOGGLE_CYCLES
) (
  input  wire logic    clk_in,
  input  wire logic    rst_in,
  input  wire logic    start_in,
  input  wire logic    wake_in,
  ssw_pilot_if.vehicle link,
  output logic         busy_out,
  output logic         woke_out,
  output logic         error_out
);
  typedef enum {V_IDLE, V_DISCOVER, V_CHARGE, V_POWER, V_STOP, V_SLEEP, V_TOG_C, V_TOG_B, V_WAIT, V_DONE, V_ERROR}
    ssw_vstate_t;

  ssw_vstate_t                 state;
  ssw_vstate_t                 next_state;
  logic [ssw_pkg::WAIT_W-1:0]  cnt;
  logic [ssw_pkg::WAIT_W-1:0]  next_cnt;
  logic [31:0]                 step;
  logic [31:0]                 next_step;
  logic [ssw_pkg::WAIT_W-1:0]  wait_target;
  logic [ssw_pkg::WAIT_W-1:0]  next_wait_target;
  logic [ssw_pkg::VAL_W-1:0]   imax;
  logic [ssw_pkg::VAL_W-1:0]   vmin;
  logic                        next_valid;
  ssw_pkg::ssw_req_t           next_code;
  logic                        next_arg;
  logic                        next_pilot_c;
  logic                        next_pause;
  logic                        pwm_meta;
  logic                        pwm_sync;

  wire rsp_param  = link.rsp_valid && (link.rsp_code == ssw_pkg::SSW_RSP_PARAM);
  wire rsp_power  = link.rsp_valid && (link.rsp_code == ssw_pkg::SSW_RSP_POWER);
  wire rsp_stop   = link.rsp_valid && (link.rsp_code == ssw_pkg::SSW_RSP_STOP);
  wire rsp_failed = link.rsp_valid && (link.rsp_code == ssw_pkg::SSW_RSP_FAILED);
  wire wait_done  = (cnt >= wait_target);
  wire step_due   = (step == STEP_CYCLES - 1);
  wire hold_done  = (cnt == ssw_pkg::WAIT_W'(TOGGLE_CYCLES - 1));

  always_comb
  begin
    next_state       = state;
    next_cnt         = cnt;
    next_step        = step;
    next_wait_target = wait_target;
    next_valid       = 1'b0;
    next_code        = ssw_pkg::SSW_REQ_NONE;
    next_arg         = 1'b0;
    next_pilot_c     = link.pilot_c;
    next_pause       = 1'b0;
    unique case (state)
      V_IDLE:
        if (start_in)
        begin
          next_valid = 1'b1;
          next_code  = ssw_pkg::SSW_REQ_PARAM;
          next_state = V_DISCOVER;
        end
      V_DISCOVER:
        if (rsp_failed)
          next_state = V_ERROR;
        // RULE_01 limits first
        else if (rsp_param)
        begin
          // RULE_04 settle time
          next_wait_target = ssw_pkg::WAIT_W'(WAIT_BASE)
                           + ssw_pkg::WAIT_W'(link.rsp_imax) * ssw_pkg::WAIT_W'(CYC_PER_AMP);
          next_valid = 1'b1;
          next_code  = ssw_pkg::SSW_REQ_CURRENT;
          next_cnt   = '0;
          next_step  = '0;
          next_state = V_CHARGE;
        end
      V_CHARGE:
      begin
        next_cnt  = cnt + 1'b1;
        next_step = step_due ? 32'h0000_0000 : step + 1'b1;
        if (rsp_failed)
          next_state = V_ERROR;
        // RULE_05 stop power
        else if (wait_done)
        begin
          next_valid = 1'b1;
          next_code  = ssw_pkg::SSW_REQ_POWER;
          next_arg   = 1'b1;
          next_state = V_POWER;
        end
        // RULE_02 demand every step
        else if (step_due)
        begin
          next_valid = 1'b1;
          next_code  = ssw_pkg::SSW_REQ_CURRENT;
        end
      end
      V_POWER:
        if (rsp_failed)
          next_state = V_ERROR;
        // RULE_06 pause session
        else if (rsp_power)
        begin
          next_valid = 1'b1;
          next_code  = ssw_pkg::SSW_REQ_STOP;
          next_arg   = 1'b1;
          next_state = V_STOP;
        end
      V_STOP:
        if (rsp_failed)
          next_state = V_ERROR;
        // RULE_07 pause link after
        else if (rsp_stop)
        begin
          next_pause = 1'b1;
          next_state = V_SLEEP;
        end
      V_SLEEP:
        if (!pwm_sync && wake_in)
        begin
          next_cnt     = '0;
          next_pilot_c = 1'b1;
          next_state   = V_TOG_C;
        end
      // RULE_09 single toggle
      V_TOG_C:
      begin
        next_cnt = cnt + 1'b1;
        if (hold_done)
        begin
          next_cnt     = '0;
          next_pilot_c = 1'b0;
          next_state   = V_TOG_B;
        end
      end
      V_TOG_B:
      begin
        next_cnt = cnt + 1'b1;
        if (hold_done)
          next_state = V_WAIT;
      end
      V_WAIT:
        if (pwm_sync)
          next_state = V_DONE;
      V_DONE:
        if (start_in)
          next_state = V_IDLE;
      V_ERROR:
        if (start_in)
          next_state = V_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    pwm_meta <= link.pwm_on;
    pwm_sync <= pwm_meta;
    if (rst_in)
    begin
      state            <= V_IDLE;
      cnt              <= '0;
      step             <= '0;
      wait_target      <= '0;
      imax             <= '0;
      vmin             <= '0;
      link.req_valid   <= 1'b0;
      link.req_code    <= ssw_pkg::SSW_REQ_NONE;
      link.req_arg     <= 1'b0;
      link.pilot_c     <= 1'b0;
      link.dlink_pause <= 1'b0;
      busy_out         <= 1'b0;
      woke_out         <= 1'b0;
      error_out        <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      cnt              <= next_cnt;
      step             <= next_step;
      wait_target      <= next_wait_target;
      link.req_valid   <= next_valid;
      link.req_code    <= next_code;
      link.req_arg     <= next_arg;
      link.pilot_c     <= next_pilot_c;
      link.dlink_pause <= next_pause;
      busy_out         <= (next_state != V_IDLE) && (next_state != V_DONE) && (next_state != V_ERROR);
      woke_out         <= (next_state == V_DONE);
      error_out        <= (next_state == V_ERROR);
      if (rsp_param && (state == V_DISCOVER))
      begin
        imax <= link.rsp_imax;
        vmin <= link.rsp_vmin;
      end
    end
  end

  // RULE_03 full current at min voltage
  assign link.req_current = imax;
  assign link.req_voltage = vmin;

endmodule

`default_nettype wire

/* File: logic/ssw_charger_end.sv */
/*
  charger end: two gun controllers, each answering its vehicle, sleeping with the
  pilot held high and waking on a full B1-C1-B1 toggle with 5 percent pwm.
  assumes the pilot state from the vehicle is asynchronous to clk_in.
*/
//Contract
//RULE_01: report limits before the sequence starts
//RULE_02: vehicle sends current demand every step
//RULE_03: vehicle requests max current, min voltage
//RULE_04: vehicle waits settle time before stopping
//RULE_05: vehicle stops power, awaits response
//RULE_06: vehicle then stops session with pause
//RULE_07: link pause only after stop response
//RULE_08: sleep: oscillator off, pilot held high
//RULE_09: vehicle wakes with one B1-C1-B1 toggle
//RULE_10: on wake, pwm restarts at five percent
//RULE_11: two guns run independently with offset
//RULE_12: incomplete toggles ignored while asleep
`timescale 1ns/1ns
`default_nettype none

module ssw_charger_gun #(
  parameter int unsigned PWM_PERIOD = ssw_pkg::PWM_PERIOD_CYCLES,
  parameter int unsigned PWM_HIGH   = ssw_pkg::PWM_HIGH_CYCLES
) (
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      enable_in,
  input  wire logic [ssw_pkg::VAL_W-1:0] vmin_in,
  input  wire logic [ssw_pkg::VAL_W-1:0] vmax_in,
  input  wire logic [ssw_pkg::VAL_W-1:0] imin_in,
  input  wire logic [ssw_pkg::VAL_W-1:0] imax_in,
  input  wire logic [ssw_pkg::VAL_W-1:0] pmax_in,
  ssw_pilot_if.charger                   link,
  output logic                           asleep_out,
  output logic                           woken_out,
  output logic [ssw_pkg::VAL_W-1:0]      target_current_out,
  output logic [ssw_pkg::VAL_W-1:0]      target_voltage_out
);
  localparam int unsigned CW = $clog2(PWM_PERIOD);

  typedef enum {C_IDLE, C_CHARGE, C_STOPPED, C_PAUSED, C_SLEEP, C_SLEEP_C} ssw_cstate_t;

  ssw_cstate_t       state;
  ssw_cstate_t       next_state;
  ssw_pkg::ssw_rsp_t next_rsp;
  logic              reported;
  logic              next_reported;
  logic              pilot_meta;
  logic              pilot_sync;
  logic [CW-1:0]     cnt;

  wire req       = link.req_valid;
  wire is_param  = req && (link.req_code == ssw_pkg::SSW_REQ_PARAM);
  wire is_cur    = req && (link.req_code == ssw_pkg::SSW_REQ_CURRENT);
  wire is_power  = req && (link.req_code == ssw_pkg::SSW_REQ_POWER);
  wire is_stop   = req && (link.req_code == ssw_pkg::SSW_REQ_STOP);
  wire next_osc  = (next_state != C_SLEEP) && (next_state != C_SLEEP_C);
  wire cnt_wrap  = (cnt == CW'(PWM_PERIOD - 1));
  // wake restarts the period so the first pulse is full length
  wire [CW-1:0] next_cnt = (!next_osc || !link.pwm_on || cnt_wrap) ? '0 : cnt + 1'b1;

  always_comb
  begin
    next_state    = state;
    next_rsp      = req ? ssw_pkg::SSW_RSP_FAILED : ssw_pkg::SSW_RSP_NONE;
    next_reported = reported;
    if (enable_in)
    begin
      unique case (state)
        C_IDLE:
          // RULE_01 limits first
          if (is_param)
          begin
            next_rsp      = ssw_pkg::SSW_RSP_PARAM;
            next_reported = 1'b1;
          end
          else if (is_cur && reported)
          begin
            next_rsp   = ssw_pkg::SSW_RSP_CURRENT;
            next_state = C_CHARGE;
          end
        C_CHARGE:
          if (is_cur)
            next_rsp = ssw_pkg::SSW_RSP_CURRENT;
          else if (is_power)
          begin
            next_rsp = ssw_pkg::SSW_RSP_POWER;
            if (link.req_arg)
              next_state = C_STOPPED;
          end
        C_STOPPED:
          if (is_stop)
          begin
            next_rsp   = ssw_pkg::SSW_RSP_STOP;
            next_state = link.req_arg ? C_PAUSED : C_IDLE;
            next_reported = link.req_arg;
          end
        C_PAUSED:
          // RULE_08 enter sleep
          if (link.dlink_pause)
            next_state = C_SLEEP;
        // RULE_12 half toggle keeps sleep
        C_SLEEP:
          if (pilot_sync)
            next_state = C_SLEEP_C;
        C_SLEEP_C:
          // RULE_10 wake on return to B1
          if (!pilot_sync)
          begin
            next_state    = C_IDLE;
            next_reported = 1'b0;
          end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    pilot_meta <= link.pilot_c;
    pilot_sync <= pilot_meta;
    if (rst_in)
    begin
      state              <= C_IDLE;
      reported           <= 1'b0;
      cnt                <= '0;
      link.rsp_valid     <= 1'b0;
      link.rsp_code      <= ssw_pkg::SSW_RSP_NONE;
      link.pwm_on        <= 1'b1;
      link.pwm_duty      <= ssw_pkg::DUTY_CODE;
      link.pilot_wave    <= 1'b1;
      asleep_out         <= 1'b0;
      woken_out          <= 1'b0;
      target_current_out <= '0;
      target_voltage_out <= '0;
    end
    else
    begin
      state           <= next_state;
      reported        <= next_reported;
      cnt             <= next_cnt;
      link.rsp_valid  <= (next_rsp != ssw_pkg::SSW_RSP_NONE);
      link.rsp_code   <= next_rsp;
      // RULE_08 oscillator off, level high
      link.pwm_on     <= next_osc;
      // RULE_10 five percent duty
      link.pwm_duty   <= next_osc ? ssw_pkg::DUTY_CODE : ssw_pkg::DUTY_OFF;
      link.pilot_wave <= !next_osc || (next_cnt < CW'(PWM_HIGH));
      asleep_out      <= !next_osc;
      woken_out       <= (state == C_SLEEP_C) && (next_state == C_IDLE);
      if (next_rsp == ssw_pkg::SSW_RSP_CURRENT)
      begin
        target_current_out <= link.req_current;
        target_voltage_out <= link.req_voltage;
      end
    end
  end

  // limits are static inputs, shown whenever a response is read
  assign link.rsp_vmin = vmin_in;
  assign link.rsp_vmax = vmax_in;
  assign link.rsp_imin = imin_in;
  assign link.rsp_imax = imax_in;
  assign link.rsp_pmax = pmax_in;

endmodule

module ssw_charger_end #(
  parameter int unsigned PWM_PERIOD = ssw_pkg::PWM_PERIOD_CYCLES,
  parameter int unsigned PWM_HIGH   = ssw_pkg::PWM_HIGH_CYCLES
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        start_in,
  input  wire logic [ssw_pkg::OFS_W-1:0]   gun_offset_in,
  input  wire logic [ssw_pkg::VAL_W-1:0]   vmin_in,
  input  wire logic [ssw_pkg::VAL_W-1:0]   vmax_in,
  input  wire logic [ssw_pkg::VAL_W-1:0]   imin_in,
  input  wire logic [ssw_pkg::VAL_W-1:0]   imax_in,
  input  wire logic [ssw_pkg::VAL_W-1:0]   pmax_in,
  ssw_pilot_if.charger                     gun0,
  ssw_pilot_if.charger                     gun1,
  output logic [1:0]                       asleep_out,
  output logic [1:0]                       woken_out,
  output logic [1:0]                       enabled_out,
  output logic [1:0][ssw_pkg::VAL_W-1:0]   target_current_out,
  output logic [1:0][ssw_pkg::VAL_W-1:0]   target_voltage_out
);
  logic [ssw_pkg::OFS_W-1:0] ofs_cnt;
  logic                      counting;

  wire ofs_hit = counting && (ofs_cnt >= gun_offset_in);

  // RULE_11 second gun after offset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ofs_cnt     <= '0;
      counting    <= 1'b0;
      enabled_out <= 2'h0;
    end
    else
    begin
      ofs_cnt     <= start_in ? '0 : ofs_cnt + ssw_pkg::OFS_W'(counting);
      counting    <= start_in || (counting && !ofs_hit);
      enabled_out <= {enabled_out[1] || ofs_hit, enabled_out[0] || start_in};
    end
  end

  ssw_charger_gun #(.PWM_PERIOD(PWM_PERIOD), .PWM_HIGH(PWM_HIGH)) u_gun0 (
    .clk_in             (clk_in),
    .rst_in             (rst_in),
    .enable_in          (enabled_out[0]),
    .vmin_in            (vmin_in),
    .vmax_in            (vmax_in),
    .imin_in            (imin_in),
    .imax_in            (imax_in),
    .pmax_in            (pmax_in),
    .link               (gun0),
    .asleep_out         (asleep_out[0]),
    .woken_out          (woken_out[0]),
    .target_current_out (target_current_out[0]),
    .target_voltage_out (target_voltage_out[0])
  );

  ssw_charger_gun #(.PWM_PERIOD(PWM_PERIOD), .PWM_HIGH(PWM_HIGH)) u_gun1 (
    .clk_in             (clk_in),
    .rst_in             (rst_in),
    .enable_in          (enabled_out[1]),
    .vmin_in            (vmin_in),
    .vmax_in            (vmax_in),
    .imin_in            (imin_in),
    .imax_in            (imax_in),
    .pmax_in            (pmax_in),
    .link               (gun1),
    .asleep_out         (asleep_out[1]),
    .woken_out          (woken_out[1]),
    .target_current_out (target_current_out[1]),
    .target_voltage_out (target_voltage_out[1])
  );

endmodule

`default_nettype wire

/* File: bench/ssw_link_sva.sv */
/*
  checker for one gun's pilot link, fed with the interface signals.
  assumes one clock, pwm high time shortened to 5 cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module ssw_link_sva (
  input wire logic                       clk_in,
  input wire logic                       rst_in,
  input wire logic                       req_valid,
  input wire ssw_pkg::ssw_req_t          req_code,
  input wire logic                       req_arg,
  input wire logic [ssw_pkg::VAL_W-1:0]  req_current,
  input wire logic [ssw_pkg::VAL_W-1:0]  req_voltage,
  input wire logic                       dlink_pause,
  input wire logic                       pilot_c,
  input wire logic                       rsp_valid,
  input wire ssw_pkg::ssw_rsp_t          rsp_code,
  input wire logic [ssw_pkg::VAL_W-1:0]  rsp_vmin,
  input wire logic [ssw_pkg::VAL_W-1:0]  rsp_imax,
  input wire logic                       pwm_on,
  input wire logic [ssw_pkg::DUTY_W-1:0] pwm_duty,
  input wire logic                       pilot_wave
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic seen_stop;
  // seen_stop clears on the pause itself so a second pause needs a new stop
  always_ff @(posedge clk_in)
  begin
    if (rst_in || dlink_pause) seen_stop <= 1'b0;
    else if (rsp_valid && rsp_code == ssw_pkg::SSW_RSP_STOP) seen_stop <= 1'b1;
  end
  property p_rsp_next; req_valid |=> rsp_valid; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("request not answered");
  property p_rsp_cause; rsp_valid |-> $past(req_valid); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");
  property p_targets; req_valid && req_code == ssw_pkg::SSW_REQ_CURRENT |-> req_current == rsp_imax
    && req_voltage == rsp_vmin; endproperty
  a_targets: assert property (p_targets) else $error("current request targets wrong");
  property p_stop_arg; req_valid && (req_code == ssw_pkg::SSW_REQ_POWER || req_code == ssw_pkg::SSW_REQ_STOP)
    |-> req_arg; endproperty
  a_stop_arg: assert property (p_stop_arg) else $error("power or stop not in pause form");
  property p_pause_after; dlink_pause |-> seen_stop; endproperty
  a_pause_after: assert property (p_pause_after) else $error("link pause before stop answer");
  property p_sleep_entry; dlink_pause |=> !pwm_on && pilot_wave && pwm_duty == ssw_pkg::DUTY_OFF; endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep after link pause");
  property p_sleep_hold; !pwm_on |-> pilot_wave && pwm_duty == ssw_pkg::DUTY_OFF; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep level not held");
  property p_toggle; $rose(pilot_c) |-> (!pwm_on && pilot_c) [*6]; endproperty
  a_toggle: assert property (p_toggle) else $error("wake toggle malformed");
  property p_wake; !pwm_on && $fell(pilot_c) |-> ##[1:5] (pwm_on && pwm_duty == ssw_pkg::DUTY_CODE); endproperty
  a_wake: assert property (p_wake) else $error("no wake after toggle");
  property p_duty; pwm_on |-> pwm_duty == ssw_pkg::DUTY_CODE; endproperty
  a_duty: assert property (p_duty) else $error("duty not five percent");
  property p_wave; pwm_on && $rose(pilot_wave) |-> pilot_wave [*5] ##1 !pilot_wave; endproperty
  a_wave: assert property (p_wave) else $error("pwm high time wrong");
  property p_no_stray; $rose(pwm_on) |-> !pilot_c && ($past(pilot_c, 3) || $past(pilot_c, 4)
    || $past(pilot_c, 5)); endproperty
  a_no_stray: assert property (p_no_stray) else $error("woke without full toggle");
  c_sleep: cover property (dlink_pause ##1 !pwm_on);
  c_wake: cover property ($rose(pwm_on));
  c_current: cover property (req_valid && req_code == ssw_pkg::SSW_REQ_CURRENT);
endmodule

`default_nettype wire

/* File: bench/tb_top.sv */
/*
  testbench: charger end facing two vehicle ends, two rounds of charge,
  sleep and wake. assumes shortened pwm and wait counts.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_c = 1'b0;
  logic [1:0] start_v = 2'b00;
  logic [1:0] wake_v = 2'b00;
  logic [31:0] ofs = 32'h0000_0028;
  logic [15:0] vmin = 16'h0064, vmax = 16'h0FA0, imin = 16'h0001, imax = 16'h000A, pmax = 16'hFFFF;
  wire logic [1:0] asleep, woken, enabled, busy, woke, err;
  wire logic [1:0][15:0] tcur, tvol;
  int n_errors = 0;
  int comparisons = 0;
  int k;
  int cyc = 0, t_param = 0, n_wk1 = 0;
  logic [15:0] notes[$];
  logic asleep_q = 1'b0;
  always #4 clk_in = ~clk_in;
  ssw_pilot_if link[2] ();
  ssw_charger_end #(.PWM_PERIOD(100), .PWM_HIGH(5)) ssw_charger_end_i (.clk_in(clk_in), .rst_in(rst_in),
    .start_in(start_c), .gun_offset_in(ofs), .vmin_in(vmin), .vmax_in(vmax), .imin_in(imin), .imax_in(imax),
    .pmax_in(pmax), .gun0(link[0]), .gun1(link[1]), .asleep_out(asleep), .woken_out(woken),
    .enabled_out(enabled), .target_current_out(tcur), .target_voltage_out(tvol));
  for (genvar g = 0; g < 2; g++)
  begin : gv
    ssw_vehicle_end #(.WAIT_BASE(50), .CYC_PER_AMP(1), .STEP_CYCLES(8), .TOGGLE_CYCLES(6)) ssw_vehicle_end_i (
      .clk_in(clk_in), .rst_in(rst_in), .start_in(start_v[g]), .wake_in(wake_v[g]), .link(link[g]),
      .busy_out(busy[g]), .woke_out(woke[g]), .error_out(err[g]));
  end
  ssw_link_sva ssw_link_sva_i (.clk_in(clk_in), .rst_in(rst_in), .req_valid(link[0].req_valid),
    .req_code(link[0].req_code), .req_arg(link[0].req_arg), .req_current(link[0].req_current),
    .req_voltage(link[0].req_voltage), .dlink_pause(link[0].dlink_pause), .pilot_c(link[0].pilot_c),
    .rsp_valid(link[0].rsp_valid), .rsp_code(link[0].rsp_code), .rsp_vmin(link[0].rsp_vmin),
    .rsp_imax(link[0].rsp_imax), .pwm_on(link[0].pwm_on), .pwm_duty(link[0].pwm_duty),
    .pilot_wave(link[0].pilot_wave));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // results are sampled mid-cycle, after the launching edge has settled
  always @(negedge clk_in)
  begin
    if (!rst_in && asleep[0] === 1'b1 && !asleep_q)
    begin
      check("target current", tcur[0], notes.pop_front());
      check("target voltage", tvol[0], notes.pop_front());
      check("sleep pilot", {15'h0000, link[0].pilot_wave}, 16'h0001);
    end
    if (woken[0] === 1'b1) check("wake duty", {9'h000, link[0].pwm_duty}, notes.pop_front());
    if (woken[1] === 1'b1) n_wk1++;
    if (link[0].rsp_valid === 1'b1 && link[0].rsp_code == ssw_pkg::SSW_RSP_PARAM) t_param = cyc;
    // settle wait plus one cycle to take the answer and one to launch the stop
    if (link[0].req_valid === 1'b1 && link[0].req_code == ssw_pkg::SSW_REQ_POWER)
      check("settle cycles", 16'(cyc - t_param), imax + 16'h0034);
    cyc++;
    asleep_q <= (asleep[0] === 1'b1);
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'hDE38));
    repeat (4) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    ofs = 32'($urandom_range(20, 60));
    for (int r = 0; r < 2; r++)
    begin
      vmin = 16'($urandom_range(50, 500));
      imax = 16'($urandom_range(1, 30));
      vmax = 16'($urandom_range(1000, 4000));
      imin = 16'($urandom_range(1, 5));
      pmax = 16'($urandom);
      notes.push_back(imax);
      notes.push_back(vmin);
      notes.push_back({9'h000, ssw_pkg::DUTY_CODE});
      // from done a start only returns the vehicle to idle
      if (r > 0)
      begin
        @(negedge clk_in) start_v = 2'b11;
        @(negedge clk_in) start_v = 2'b00;
      end
      @(negedge clk_in) start_c = 1'b1;
      start_v = 2'b01;
      @(negedge clk_in) start_c = 1'b0;
      start_v = (r > 0) ? 2'b10 : 2'b00;
      if (r == 0)
      begin
        for (k = 1; k < 200 && enabled[1] !== 1'b1; k++) @(negedge clk_in);
        check("gun offset", {15'h0000, k >= ofs && k <= ofs + 4}, 16'h0001);
        check("guns enabled", {14'h0000, enabled}, 16'h0003);
        start_v = 2'b10;
      end
      @(negedge clk_in) start_v = 2'b00;
      for (k = 0; k < 3000 && asleep !== 2'b11; k++) @(negedge clk_in);
      check("limit vmin", link[0].rsp_vmin, vmin);
      check("limit imax", link[1].rsp_imax, imax);
      check("limit pmax", link[0].rsp_pmax, pmax);
      repeat (30) @(negedge clk_in);
      check("still asleep", {14'h0000, asleep}, 16'h0003);
      check("vehicle busy", {14'h0000, busy}, 16'h0003);
      check("osc off", {15'h0000, link[1].pwm_on}, 16'h0000);
      wake_v = 2'b01;
      for (k = 0; k < 20 && link[0].pilot_c !== 1'b1; k++) @(negedge clk_in);
      repeat (4) @(negedge clk_in);
      check("half toggle", {15'h0000, asleep[0]}, 16'h0001);
      for (k = 0; k < 500 && woke[0] !== 1'b1; k++) @(negedge clk_in);
      check("gun1 apart", {15'h0000, asleep[1]}, 16'h0001);
      wake_v = 2'b11;
      for (k = 0; k < 500 && woke[1] !== 1'b1; k++) @(negedge clk_in);
      wake_v = 2'b00;
      check("gun1 duty", {9'h000, link[1].pwm_duty}, {9'h000, ssw_pkg::DUTY_CODE});
      check("gun1 current", tcur[1], imax);
      check("gun1 voltage", tvol[1], vmin);
      check("gun1 woken", 16'(n_wk1), 16'(r + 1));
      check("vehicle idle", {14'h0000, busy}, 16'h0000);
      check("vehicle errors", {14'h0000, err}, 16'h0000);
    end
    repeat (4) @(negedge clk_in);
    check("notes left", 16'(notes.size()), 16'h0000);
    wrap_up();
  end
endmodule

`default_nettype wire
